// ===== rtl/input_qual_pkg.sv
package input_qual_pkg;
  // Field layouts
  localparam int PERIOD_W        = 8;
  localparam int GROUP_PINS      = 8;
  localparam int STBY_QUAL_W     = 6;
  localparam int SAMPLES_THREE   = 3;
  localparam int SAMPLES_SIX     = 6;
  // Reset values
  localparam logic [7:0] PERIOD_RST    = 8'h00;
  localparam logic [5:0] STBY_QUAL_RST = 6'h00;
  // Timing
  localparam int CLOCK_MHZ          = 50;
  localparam int WAKE_ACTIVE_CYCLES = 20;
  localparam int WAKE_SLEEP_CYCLES  = 1050;
  localparam int STBY_MIN_NOQUAL    = 3;
  localparam int STBY_QUAL_BASE     = 2;
  // Wake sequencer states
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_IDLE = 3'b010,
    ST_WAKE = 3'b100
  } wake_state_t;
endpackage

// ===== rtl/qual_pin.sv
`timescale 1ns/100ps
module qual_pin (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // Control
  input  wire logic i_sample_tick,
  input  wire logic i_async_mode,
  input  wire logic i_six_sample,
  // Pin
  input  wire logic i_pin,
  // Result
  output logic      o_level
);
  logic       sync1_q;
  logic       sync2_q;
  logic [5:0] hist_q;
  logic       level_q;
  logic       all_hi;
  logic       all_lo;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hist_q <= 6'h00;
    end else if (i_sample_tick) begin
      hist_q <= {hist_q[4:0], sync2_q};
    end
  end

  // R5 three or six
  assign all_hi = i_six_sample ? (&hist_q) : (&hist_q[2:0]);
  assign all_lo = i_six_sample ? ~(|hist_q) : ~(|hist_q[2:0]);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      level_q <= 1'b0;
    // R17 plain synchronised path
    end else if (i_async_mode) begin
      level_q <= sync2_q;
    // R16 unanimous window only
    end else if (all_hi) begin
      level_q <= 1'b1;
    end else if (all_lo) begin
      level_q <= 1'b0;
    end
  end

  assign o_level = level_q;

  // R16 split window holds
  hold_level_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R16
    (!i_async_mode && !all_hi && !all_lo) |=> $stable(level_q)) else $error("level moved without agreement");
endmodule // qual_pin

// ===== rtl/input_qualifier_wake_timing.sv
`timescale 1ns/100ps
// How it works
// R1: The group sampling period field takes any value from 0x00 to 0xFF.
// R2: A period field of zero samples the pin every system clock cycle.
// R3: A nonzero period field n samples once every 2n system clock cycles.
// R4: One period field serves a group of eight consecutive pins.
// R5: Each pin selects three or six samples per decision.
// R6: Three samples make a window of two sampling periods.
// R7: Six samples make a window of five sampling periods.
// R8: The source holds each level two cycles, or window plus period plus one cycle when qualified.
// R9: The conversion-start interrupt input obeys the same pulse-width limits.
// R10: An idle wake signal lasts two cycles, or five cycles plus a window when qualified.
// R11: Wake from idle with active flash or RAM resumes within 20 cycles plus the window.
// R12: Wake from idle with sleeping flash resumes within 1050 cycles plus the window.
// R13: Wake latency ends at the instruction after idle; service routines add more.
// R14: Idle ends on an enabled interrupt, watchdog, nonmaskable interrupt or reset pin.
// R15: Standby wake qualification is a 6-bit count; the pulse lasts 3 or 2 plus count oscillator cycles.
// R16: The qualified output changes only when all window samples agree.
// R17: Synchronous mode passes the pin through a synchroniser with no filter.
module input_qualifier_wake_timing #(
  parameter int GROUPS = 2
) (
  // Clock and reset
  input  wire logic                         i_clock,
  input  wire logic                         i_sys_rst,
  // Qualifier configuration
  input  wire logic [GROUPS*8-1:0]          i_sample_period_divider,
  input  wire logic [GROUPS*8-1:0]          i_sync_mode,
  input  wire logic [GROUPS*8-1:0]          i_qual_sample_select_reg,
  // Pins
  input  wire logic [GROUPS*8-1:0]          i_pins,
  output logic      [GROUPS*8-1:0]          o_qualified,
  // Idle wake
  input  wire logic                         i_idle_enter,
  input  wire logic                         i_flash_sleep,
  input  wire logic [GROUPS*8-1:0]          i_wake_enable,
  input  wire logic                         i_enabled_irq,
  input  wire logic                         i_watchdog_wake_irq,
  input  wire logic                         i_ext_nonmaskable_irq,
  input  wire logic                         i_ext_reset_pin_n,
  output logic                              o_idle,
  output logic                              o_resume,
  // Standby wake qualifier on oscillator clock ticks
  input  wire logic                         i_osc_tick,
  input  wire logic [5:0]                   i_standby_wake_qual_count,
  input  wire logic                         i_standby_qual_en,
  input  wire logic                         i_standby_wake_pin,
  output logic                              o_standby_wake
);
  localparam int NPINS = GROUPS * input_qual_pkg::GROUP_PINS;

  logic [GROUPS-1:0] tick;
  logic [NPINS-1:0]  qual;

  genvar g;
  genvar p;
  generate
    for (g = 0; g < GROUPS; g++) begin : grp
      logic [8:0] cnt_q;
      logic [7:0] prd;
      assign prd = i_sample_period_divider[g*8 +: 8];
      // R1 R2 R3 period divider
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          cnt_q <= 9'h000;
        // Zero period ticks at once, not after a stale reload
        end else if (prd == 8'h00) begin
          cnt_q <= 9'h000;
        end else if (cnt_q == 9'h000) begin
          cnt_q <= (prd == 8'h00) ? 9'h000 : ({prd, 1'b0} - 9'h001);
        end else begin
          cnt_q <= cnt_q - 9'h001;
        end
      end
      assign tick[g] = (cnt_q == 9'h000);
      // R4 shared tick
      for (p = 0; p < 8; p++) begin : pin
        // R6 R7 window spans samples minus one
        qual_pin u_pin (
          .i_clock      (i_clock),
          .i_sys_rst    (i_sys_rst),
          .i_sample_tick(tick[g]),
          .i_async_mode (i_sync_mode[g*8+p]),
          .i_six_sample (i_qual_sample_select_reg[g*8+p]),
          .i_pin        (i_pins[g*8+p]),
          .o_level      (qual[g*8+p])
        );
      end
    end
  endgenerate

  assign o_qualified = qual;

  // Wake sources; external ones synchronised
  logic [2:0] ext_s1_q;
  logic [2:0] ext_s2_q;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ext_s1_q <= 3'h0;
      ext_s2_q <= 3'h0;
    end else begin
      ext_s1_q <= {i_watchdog_wake_irq, i_ext_nonmaskable_irq, ~i_ext_reset_pin_n};
      ext_s2_q <= ext_s1_q;
    end
  end

  logic wake_evt;
  // R14 wake sources
  assign wake_evt = i_enabled_irq | (|ext_s2_q) | (|(qual & i_wake_enable));

  input_qual_pkg::wake_state_t state_q;
  logic [10:0] lat_q;
  logic        resume_q;

  // R11 R12 R13 bounded resume latency
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q  <= input_qual_pkg::ST_RUN;
      lat_q    <= 11'h000;
      resume_q <= 1'b0;
    end else begin
      resume_q <= 1'b0;
      case (state_q)
        input_qual_pkg::ST_RUN: begin
          if (i_idle_enter) begin
            state_q <= input_qual_pkg::ST_IDLE;
          end
        end
        input_qual_pkg::ST_IDLE: begin
          if (wake_evt) begin
            state_q <= input_qual_pkg::ST_WAKE;
            // Pin sync and qualified level already used five cycles
            lat_q   <= i_flash_sleep ? 11'(input_qual_pkg::WAKE_SLEEP_CYCLES - 5)
                                     : 11'(input_qual_pkg::WAKE_ACTIVE_CYCLES - 5);
          end
        end
        input_qual_pkg::ST_WAKE: begin
          if (lat_q == 11'h000) begin
            state_q  <= input_qual_pkg::ST_RUN;
            resume_q <= 1'b1;
          end else begin
            lat_q <= lat_q - 11'h001;
          end
        end
        default: state_q <= input_qual_pkg::ST_RUN;
      endcase
    end
  end

  assign o_idle   = (state_q != input_qual_pkg::ST_RUN);
  assign o_resume = resume_q;

  // Standby wake qualifier: pin must hold for the count plus 2 oscillator ticks, or 3 without qualification
  logic       sb1_q;
  logic       sb2_q;
  logic [6:0] sb_cnt_q;
  logic       sb_wake_q;
  logic [6:0] sb_need;
  // R15 standby pulse length
  assign sb_need = i_standby_qual_en ? 7'(input_qual_pkg::STBY_QUAL_BASE + i_standby_wake_qual_count)
                                     : 7'(input_qual_pkg::STBY_MIN_NOQUAL);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sb1_q     <= 1'b0;
      sb2_q     <= 1'b0;
      sb_cnt_q  <= 7'h00;
      sb_wake_q <= 1'b0;
    end else begin
      sb1_q <= i_standby_wake_pin;
      sb2_q <= sb1_q;
      if (!sb2_q) begin
        sb_cnt_q  <= 7'h00;
        sb_wake_q <= 1'b0;
      end else if (i_osc_tick && sb_cnt_q < sb_need) begin
        sb_cnt_q <= sb_cnt_q + 7'h01;
      end else if (sb_cnt_q >= sb_need) begin
        sb_wake_q <= 1'b1;
      end
    end
  end
  assign o_standby_wake = sb_wake_q;

  // R11 resume bound on active flash
  sequence wake_seen_s;
    (state_q == input_qual_pkg::ST_IDLE) && wake_evt && !i_flash_sleep;
  endsequence
  resume_active_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R11
    wake_seen_s |-> ##[1:20] resume_q) else $error("resume late");
  // R12 sleep wait counter
  // Too long for a delay range, so cycles are counted here
  logic [10:0] slp_wait_q;
  logic        slp_armed_q;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      slp_armed_q <= 1'b0;
      slp_wait_q  <= 11'h000;
    end else if ((state_q == input_qual_pkg::ST_IDLE) && wake_evt && i_flash_sleep) begin
      slp_armed_q <= 1'b1;
      slp_wait_q  <= 11'h000;
    end else if (resume_q) begin
      slp_armed_q <= 1'b0;
    end else if (slp_armed_q) begin
      slp_wait_q <= slp_wait_q + 11'h001;
    end
  end
  resume_sleep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R12
    (slp_armed_q && !resume_q) |-> (slp_wait_q < 11'(input_qual_pkg::WAKE_SLEEP_CYCLES - 1)))
    else $error("resume late from sleep");
  resume_once_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R13
    resume_q |-> (state_q == input_qual_pkg::ST_RUN) && !$past(resume_q)) else $error("bad resume");
  zero_tick_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R2
    (i_sample_period_divider[7:0] == 8'h00 && $past(i_sample_period_divider[7:0]) == 8'h00) |-> tick[0])
    else $error("no tick at zero period");
  tick_space_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R3
    (tick[0] && i_sample_period_divider[7:0] == 8'h01 && $stable(i_sample_period_divider[7:0]))
      |=> !tick[0] ##1 tick[0]) else $error("tick spacing wrong");
  wake_src_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R14
    (state_q == input_qual_pkg::ST_IDLE && ext_s2_q != 3'h0) |=> state_q == input_qual_pkg::ST_WAKE)
    else $error("wake source ignored");
  stby_qual_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R15
    $rose(sb_wake_q) |-> sb_cnt_q >= sb_need) else $error("standby wake early");
  stby_drop_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R15
    !sb2_q |=> !sb_wake_q) else $error("standby wake held");
endmodule // input_qualifier_wake_timing

// ===== verif/pin_source.sv
`timescale 1ns/100ps
module pin_source (
  // Clock
  input  wire logic i_clock,
  // Pin
  output logic      o_pin
);
  initial o_pin = 1'b0;
  // whole-cycle hold
  // Level moves just after an edge, so the width is exact in cycles
  task automatic drive(input logic lvl, input int cyc);
    #1 o_pin = lvl;
    repeat (cyc) @(posedge i_clock);
  endtask
endmodule // pin_source

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [7:0] p; logic six; logic sy; logic g; logic ok;} row_t;
  logic [15:0] prd, sync_m, qsel, pins, qual, wen;
  logic        clk, rst, ie, fs, irq, wd, nmi, rpn, idle, resume;
  logic        tick, sq_en, spin, swake, src_pin, seen, sseen;
  logic [5:0]  sqc;
  int          sel, n_errors, num_checks;
  logic [11:0] rows [11] = '{12'h000, 12'h001, 12'h008, 12'h009, 12'h010, 12'h013,
                             12'h038, 12'h039, 12'hFF2, 12'hFF3, 12'h00D};
  logic [5:0]  scnt [3] = '{6'h00, 6'h05, 6'h3F};

  pin_source src (.i_clock(clk), .o_pin(src_pin));
  assign pins = 16'(src_pin) << sel;

  input_qualifier_wake_timing #(.GROUPS(2)) uut (
    .i_clock(clk), .i_sys_rst(rst), .i_sample_period_divider(prd), .i_sync_mode(sync_m),
    .i_qual_sample_select_reg(qsel), .i_pins(pins), .o_qualified(qual), .i_idle_enter(ie),
    .i_flash_sleep(fs), .i_wake_enable(wen), .i_enabled_irq(irq), .i_watchdog_wake_irq(wd),
    .i_ext_nonmaskable_irq(nmi), .i_ext_reset_pin_n(rpn), .o_idle(idle), .o_resume(resume),
    .i_osc_tick(tick), .i_standby_wake_qual_count(sqc), .i_standby_qual_en(sq_en),
    .i_standby_wake_pin(spin), .o_standby_wake(swake));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Oscillator tick every other cycle
  always @(posedge clk) tick <= #1 ~tick;
  always @(posedge clk) begin
    if (qual[sel] === 1'b1) seen <= 1'b1;
    if (swake === 1'b1) sseen <= 1'b1;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Glitch one sample short of a window, or a pulse of window plus period plus one
  task automatic qual_case(input row_t r);
    int sp, n, w;
    sp = (r.p == 8'h00) ? 1 : 2 * r.p;
    n = r.six ? input_qual_pkg::SAMPLES_SIX : input_qual_pkg::SAMPLES_THREE;
    w = r.sy ? 2 : (r.ok ? sp * n + 1 : sp * (n - 1));
    @(posedge clk);
    #1 prd = 16'h0000;
    prd[r.g*8 +: 8] = r.p;
    qsel = {16{r.six}};
    sync_m = {16{r.sy}};
    sel = r.g * 8;
    repeat (2) @(posedge clk);
    seen = 1'b0;
    src.drive(1'b1, w);
    src.drive(1'b0, 14 * sp + 10);
    #1 cmp(16'(seen), 16'(r.ok));
    cmp(16'(qual[sel]), 16'h0000);
  endtask

  task automatic idle_case(input int s, input logic f);
    int k, lim;
    lim = f ? input_qual_pkg::WAKE_SLEEP_CYCLES : input_qual_pkg::WAKE_ACTIVE_CYCLES;
    @(posedge clk);
    #1 fs = f;
    ie = 1'b1;
    @(posedge clk);
    #1 ie = 1'b0;
    @(posedge clk);
    #1 cmp(16'(idle), 16'h0001);
    {irq, wd, nmi, rpn} = 4'b0001 ^ (4'b1000 >> s);
    // Case four wakes through an enabled pin in sync mode
    if (s == 4) begin
      sel = 0;
      sync_m = 16'hFFFF;
      wen = 16'h0001;
      src.drive(1'b1, 0);
    end
    for (k = 0; k < lim && resume !== 1'b1; k++) @(posedge clk) #1;
    cmp(16'(resume), 16'h0001);
    cmp(16'(idle), 16'h0000);
    {irq, wd, nmi, rpn} = 4'b0001;
    wen = 16'h0000;
    src.drive(1'b0, 0);
    repeat (4) @(posedge clk);
  endtask

  // Pulse covering one or two ticks too few, or comfortably enough ticks
  task automatic stby_case(input logic [5:0] c, input logic e, input logic ok);
    int need;
    need = e ? input_qual_pkg::STBY_QUAL_BASE + c : input_qual_pkg::STBY_MIN_NOQUAL;
    @(posedge clk);
    #1 sqc = c;
    sq_en = e;
    sseen = 1'b0;
    spin = 1'b1;
    repeat (ok ? 2 * need + 4 : 2 * need - 3) @(posedge clk);
    #1 spin = 1'b0;
    repeat (4) @(posedge clk);
    cmp(16'(sseen), 16'(ok));
    cmp(16'(swake), 16'h0000);
  endtask

  initial begin
    rst = 1'b1;
    {tick, ie, fs, irq, wd, nmi, sq_en, spin, sqc, seen, sseen} = '0;
    {prd, sync_m, qsel, wen} = '0;
    rpn = 1'b1;
    sel = 0;
    n_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    #1 cmp(qual, 16'h0000);
    cmp({13'h0000, idle, resume, swake}, 16'h0000);
    rst = 1'b0;
    foreach (rows[i]) qual_case(row_t'(rows[i]));
    for (int s = 0; s < 5; s++) idle_case(s, 1'b0);
    idle_case(0, 1'b1);
    for (int i = 0; i < 6; i++) stby_case(scnt[i/2], i > 1, i[0]);
    tally_and_finish;
  end

  // Slowest row is near 8700 cycles; allow more than twice the total
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end
endmodule // tb
